// >>> rtl/pll_cfg_map.svh
// register offsets, field positions, reset values of the pll configuration
`ifndef PLL_CFG_MAP_SVH
`define PLL_CFG_MAP_SVH

// apb register byte offsets
`define PLL_OFS_CTRL     12'h000
`define PLL_OFS_CONFIG   12'h004
`define PLL_OFS_SHIFT    12'h008
`define PLL_OFS_PINS     12'h00C

// control register fields
`define PLL_CTRL_HOLD    0
`define PLL_CTRL_RST     1'b0

// config register fields
`define PLL_CFG_M_LSB    0
`define PLL_CFG_N_LSB    9
`define PLL_CFG_T_LSB    11
`define PLL_CFG_GATE     14

// serial shift register layout, msb first in time
`define PLL_SR_LEN       14
`define PLL_SR_M_LSB     0
`define PLL_SR_N_LSB     9
`define PLL_SR_T_LSB     11

// configuration reset values
`define PLL_M_RST        9'h1FF
`define PLL_N_RST        2'h3
`define PLL_T_RST        3'h0

// pin defaults when a pin group is left open
`define PLL_SER_OPEN     1'b0
`define PLL_PAR_OPEN     1'b1

`endif

// >>> rtl/pll_cfg_pkg.sv
// types shared by the pll configuration logic
package pll_cfg_pkg;

	typedef struct packed {
		logic [2:0] t;
		logic [1:0] n;
		logic [8:0] m;
	} pll_cfg_t;

	typedef struct packed {
		logic s_load;
		logic s_data;
		logic s_clock;
	} ser_pins_t;

	typedef struct packed {
		logic       p_load_n;
		logic [8:0] m;
		logic [1:0] n;
		logic       oe;
	} par_pins_t;

	typedef enum logic [1:0] {
		GATE_OFF = 2'b01,
		GATE_ON  = 2'b10
	} gate_state_t;

endpackage : pll_cfg_pkg

// >>> rtl/pll_post_div.sv
// post divider with runt-free synchronous output gate
module pll_post_div
	import pll_cfg_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	// control
	input  wire logic [1:0] div_sel_i,
	input  wire logic       gate_req_i,
	// clocks out
	output logic            vco_o,
	output logic            f_out_o,
	output logic            f_out_n_o,
	output logic            gate_on_o
);

	logic [2:0]  cnt;
	logic [2:0]  mask;
	logic        tick;
	logic        phase;
	logic        next_phase;
	gate_state_t gate;
	gate_state_t next_gate;

	// toggle every 2^n system cycles; the vco toggles every cycle
	always_comb
	begin
		unique case (div_sel_i)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
		endcase
	end

	assign tick       = ((cnt & mask) == mask);
	assign next_phase = tick ? ~phase : phase;

	// gate only moves just before a rising edge, so no pulse is cut
	always_comb
	begin
		next_gate = gate;
		if (tick && !phase)
			next_gate = gate_req_i ? GATE_ON : GATE_OFF;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			cnt <= 3'h0;
		else
			cnt <= cnt + 3'h1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			phase <= 1'b0;
			gate  <= GATE_OFF;
		end
		else
		begin
			phase <= next_phase;
			gate  <= next_gate;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			vco_o     <= 1'b0;
			f_out_o   <= 1'b0;
			f_out_n_o <= 1'b1;
			gate_on_o <= 1'b0;
		end
		else
		begin
			vco_o     <= ~vco_o;
			f_out_o   <= next_phase & (next_gate == GATE_ON);
			f_out_n_o <= ~(next_phase & (next_gate == GATE_ON));
			gate_on_o <= (next_gate == GATE_ON);
		end
	end

endmodule : pll_post_div

// >>> rtl/pll_synth_config_interface.sv
// configuration latches, serial and parallel load paths, apb access
`include "pll_cfg_map.svh"

// Functional notes
// - The output divider divides the vco by 1, 2, 4 or 8 for codes 0..3.
// - The synthesized clock is the vco clock after the post divider.
// - Outputs run when the output gate is 1 and stay disabled when 0; the code also keeps them disabled while the software hold bit is set.
// - Gate changes are aligned to the output clock so no runt appears.
// - Each rising serial clock edge shifts the serial data bit in.
// - High serial strobe makes latches follow the shift register, fall holds.
// - Low parallel strobe makes latches follow the pins, rise holds them.
// - A nine-bit loop divide value is caught from pins, bit 8 is the msb.
// - The two-bit post divide select is caught from pins and sets the divider.
// - A three-bit test select, loaded only serially, picks the monitor output.
// - Open serial strobe, data and clock pins read low.
// - Open parallel strobe, divide pins and gate pin read high.
module pll_synth_config_interface
	import pll_cfg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// serial configuration pins
	input  wire ser_pins_t   ser_i,
	input  wire logic        ser_drv_i,
	// parallel configuration pins
	input  wire par_pins_t   par_i,
	input  wire logic        par_drv_i,
	// synthesizer outputs
	output logic             f_out_o,
	output logic             f_out_n_o,
	output logic             test_o,
	output pll_cfg_t         cfg_o
);

	// resolved pin levels
	ser_pins_t ser;
	par_pins_t par;

	// serial path
	logic [`PLL_SR_LEN-1:0] shift_reg;
	logic                   s_clock_d;
	logic                   s_clk_rise;
	pll_cfg_t               sr_cfg;

	// configuration latches
	pll_cfg_t cfg;
	pll_cfg_t next_cfg;

	// software control
	logic ctrl_hold;

	// divider gate request and outputs
	logic vco;
	logic f_out;
	logic f_out_n;
	logic gate_on;
	logic gate_req;

	// apb decode
	logic        apb_acc;
	logic        apb_wr;
	logic        apb_rd;
	logic        addr_ok;
	logic [31:0] rd_mux;

	// open pins fall back to their pull levels
	always_comb
	begin
		ser = ser_i;
		if (!ser_drv_i)
		begin
			ser.s_load  = `PLL_SER_OPEN;
			ser.s_data  = `PLL_SER_OPEN;
			ser.s_clock = `PLL_SER_OPEN;
		end
	end

	always_comb
	begin
		par = par_i;
		if (!par_drv_i)
		begin
			par.p_load_n = `PLL_PAR_OPEN;
			par.m        = {9{`PLL_PAR_OPEN}};
			par.n        = {2{`PLL_PAR_OPEN}};
			par.oe       = `PLL_PAR_OPEN;
		end
	end

	// serial clock is a synchronous pin, sampled for its rising edge
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			s_clock_d <= 1'b0;
		else
			s_clock_d <= ser.s_clock;
	end

	assign s_clk_rise = ser.s_clock & ~s_clock_d;

	// fourteen bits, shifted in at the lsb end
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			shift_reg <= '0;
		else if (s_clk_rise)
			shift_reg <= {shift_reg[`PLL_SR_LEN-2:0], ser.s_data};
	end

	// field view of the shift register
	always_comb
	begin
		sr_cfg.t = shift_reg[`PLL_SR_T_LSB +: 3];
		sr_cfg.n = shift_reg[`PLL_SR_N_LSB +: 2];
		sr_cfg.m = shift_reg[`PLL_SR_M_LSB +: 9];
	end

	// the latches are flops that follow their source while open; the
	// value held after a strobe edge is the one of the cycle before it.
	// with both strobes open the serial source wins, a case the
	// controller is expected to avoid
	always_comb
	begin
		next_cfg = cfg;
		if (ser.s_load)
		begin
			// depends on the shift register being still at the fall
			next_cfg = sr_cfg;
		end
		else if (!par.p_load_n)
		begin
			// pins are expected steady across the strobe rise
			next_cfg.m = par.m;
			next_cfg.n = par.n;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			cfg.m <= `PLL_M_RST;
			cfg.n <= `PLL_N_RST;
			cfg.t <= `PLL_T_RST;
		end
		else
			cfg <= next_cfg;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			cfg_o <= '0;
		else
			cfg_o <= cfg;
	end

	// software hold forces the gate closed over the pin
	assign gate_req = par.oe & ~ctrl_hold;

	pll_post_div u_post_div
	(
		.clk_sys_i  (clk_sys_i),
		.nrst_i     (nrst_i),
		.div_sel_i  (cfg.n),
		.gate_req_i (gate_req),
		.vco_o      (vco),
		.f_out_o    (f_out),
		.f_out_n_o  (f_out_n),
		.gate_on_o  (gate_on)
	);

	assign f_out_o   = f_out;
	assign f_out_n_o = f_out_n;

	// monitor output selected by the serially loaded field
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			test_o <= 1'b0;
		else
		begin
			unique case (cfg.t)
				3'h0: test_o <= shift_reg[`PLL_SR_LEN-1];
				3'h1: test_o <= 1'b1;
				3'h2: test_o <= 1'b0;
				3'h3: test_o <= vco;
				3'h4: test_o <= f_out;
				3'h5: test_o <= ser.s_clock;
				3'h6: test_o <= par.p_load_n;
				3'h7: test_o <= gate_on;
			endcase
		end
	end

	// apb: zero wait states, error on unmapped words
	assign apb_acc  = psel_i & penable_i;
	assign apb_wr   = apb_acc & pwrite_i;
	assign apb_rd   = apb_acc & ~pwrite_i;
	assign pready_o = 1'b1;

	always_comb
	begin
		addr_ok = 1'b1;
		rd_mux  = 32'h0000_0000;
		unique case (paddr_i)
			`PLL_OFS_CTRL:
			begin
				rd_mux[`PLL_CTRL_HOLD] = ctrl_hold;
			end
			`PLL_OFS_CONFIG:
			begin
				rd_mux[`PLL_CFG_M_LSB +: 9] = cfg.m;
				rd_mux[`PLL_CFG_N_LSB +: 2] = cfg.n;
				rd_mux[`PLL_CFG_T_LSB +: 3] = cfg.t;
				rd_mux[`PLL_CFG_GATE]       = gate_on;
			end
			`PLL_OFS_SHIFT:
			begin
				rd_mux[`PLL_SR_LEN-1:0] = shift_reg;
			end
			`PLL_OFS_PINS:
			begin
				rd_mux[2:0]  = ser;
				rd_mux[15:3] = par;
			end
			default:
			begin
				addr_ok = 1'b0;
			end
		endcase
	end

	assign pslverr_o = apb_acc & ~addr_ok;

	// only the hold bit is writable; byte lane 0 carries it
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			ctrl_hold <= `PLL_CTRL_RST;
		else if (apb_wr && pstrb_i[0] && paddr_i == `PLL_OFS_CTRL)
			ctrl_hold <= pwdata_i[`PLL_CTRL_HOLD];
	end

	// read data comes from a flop, so it is captured in the setup cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= rd_mux;
		else if (!apb_rd)
			prdata_o <= 32'h0000_0000;
	end

endmodule : pll_synth_config_interface

// >>> verification/pll_cfg_sva.sv
// port checks of the pll configuration block
module pll_cfg_sva
	import pll_cfg_pkg::*;
(
	// clock and reset
	input wire logic      clk_sys_i,
	input wire logic      nrst_i,
	// pins
	input wire ser_pins_t ser_i,
	input wire logic      ser_drv_i,
	input wire par_pins_t par_i,
	input wire logic      par_drv_i,
	// outputs
	input wire logic      f_out_o,
	input wire logic      f_out_n_o,
	input wire logic      test_o,
	input wire pll_cfg_t  cfg_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic quiet;
	logic par_ld;
	assign par_ld = par_drv_i && !par_i.p_load_n;
	assign quiet = !par_ld && !(ser_drv_i && ser_i.s_load);
	sequence n1_run;
		(cfg_o.n == 2'h1)[*4];
	endsequence
	chk_fout_pair: assert property (
		f_out_n_o == !f_out_o) else $error("outputs not complementary");
	chk_div_two: assert property (
		n1_run ##1 ($rose(f_out_o) && cfg_o.n == 2'h1) ##1 n1_run
		|-> $past(f_out_o, 3) && !$past(f_out_o, 2) && !$past(f_out_o))
		else $error("divide by two period wrong");
	chk_no_runt: assert property (
		$rose(f_out_o) && cfg_o.n == 2'h3 && $past(cfg_o.n, 8) == 2'h3
		|-> f_out_o[*8]) else $error("short high phase");
	chk_gate_off: assert property (
		(par_drv_i && !par_i.oe)[*8] ##1 (par_drv_i && !par_i.oe)[*8]
		|-> !f_out_o) else $error("output runs while disabled");
	chk_par_take: assert property (
		par_ld && !(ser_drv_i && ser_i.s_load) |-> ##2
		cfg_o.m == $past(par_i.m, 2) && cfg_o.n == $past(par_i.n, 2))
		else $error("parallel load not taken");
	chk_cfg_hold: assert property (
		quiet[*4] |-> $stable(cfg_o)) else $error("config moved");
	chk_test_one: assert property (
		cfg_o.t == 3'h1 && $stable(cfg_o.t) |-> test_o)
		else $error("monitor not high");
	chk_test_zero: assert property (
		cfg_o.t == 3'h2 && $stable(cfg_o.t) |-> !test_o)
		else $error("monitor not low");
endmodule : pll_cfg_sva

// >>> verification/pll_cfg_ctrl.sv
// configuration controller model driving serial and parallel pins
module pll_cfg_ctrl
	import pll_cfg_pkg::*;
(
	// clock
	input  wire logic clk_sys_i,
	// pins towards the block
	output ser_pins_t ser_o,
	output logic      ser_drv_o,
	output par_pins_t par_o,
	output logic      par_drv_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		ser_o = '0;
		ser_drv_o = 1'b0;
		par_o = '1;
		par_drv_o = 1'b0;
	end
	// first bit ends in the top of the register
	task automatic ser_load(input logic [13:0] w);
		for (int i = 13; i >= 0; i--)
		begin
			@(posedge clk_sys_i);
			ser_drv_o <= 1'b1;
			ser_o <= '{1'b0, w[i], 1'b0};
			@(posedge clk_sys_i);
			ser_o.s_clock <= 1'b1;
		end
		@(posedge clk_sys_i);
		ser_o <= '{1'b1, 1'b0, 1'b0};
		@(posedge clk_sys_i);
		ser_drv_o <= 1'b0;
		// pulled low now: drive garbage to catch a leak
		ser_o <= 3'b011;
	endtask : ser_load
	task automatic par_load(input logic [8:0] m, input logic [1:0] n,
		input logic oe);
		@(posedge clk_sys_i);
		par_drv_o <= 1'b1;
		par_o <= '{1'b0, m, n, oe};
		@(posedge clk_sys_i);
		par_o.p_load_n <= 1'b1;
	endtask : par_load
endmodule : pll_cfg_ctrl

// >>> verification/pll_synth_config_interface_tb_top.sv
// testbench top for the pll configuration block
module pll_synth_config_interface_tb_top;
	import pll_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [3:0]  pstrb_i = 4'hF;
	logic        pready_o, pslverr_o, f_out_o, f_out_n_o, test_o;
	logic [31:0] prdata_o, q;
	logic        last_err = 1'b0;
	ser_pins_t   ser_i;
	par_pins_t   par_i;
	logic        ser_drv_i, par_drv_i;
	pll_cfg_t    cfg_o;
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	pll_synth_config_interface dut (.*);
	pll_cfg_ctrl u_ctl (.clk_sys_i, .ser_o(ser_i), .ser_drv_o(ser_drv_i),
		.par_o(par_i), .par_drv_o(par_drv_i));
	task automatic end_sim;
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_sys_i);
		while (pready_o !== 1'b1);
		r = prdata_o;
		last_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	// clocks from one rise of the output to the next
	task automatic per(output logic [31:0] c);
		while (f_out_o !== 1'b0) @(posedge clk_sys_i);
		while (f_out_o !== 1'b1) @(posedge clk_sys_i);
		c = 0;
		do begin @(posedge clk_sys_i); c++; end while (f_out_o !== 1'b0);
		do begin @(posedge clk_sys_i); c++; end while (f_out_o !== 1'b1);
	endtask : per
	task automatic low_chk;
		logic [31:0] h;
		h = 0;
		repeat (40) @(posedge clk_sys_i);
		repeat (20)
		begin
			@(posedge clk_sys_i);
			h += 32'(f_out_o !== 1'b0);
		end
		chk(h, 32'h0);
	endtask : low_chk
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim;
		end
	end
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		apb(1'b0, 12'h00C, '0, q);
		chk(q, 32'h0000_FFF8);
		chk({31'h0, last_err}, 32'h0);
		apb(1'b0, 12'h010, '0, q);
		chk(q, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		for (int n = 0; n < 4; n++)
		begin
			u_ctl.par_load(9'h155, 2'(n), 1'b1);
			per(q);
			per(q);
			chk(q, 32'(2 << n));
			chk(32'(cfg_o), {21'h0, 2'(n), 9'h155});
		end
		u_ctl.par_o.m <= 9'h0AA;
		apb(1'b1, 12'h000, 32'h1, q);
		low_chk();
		apb(1'b0, 12'h004, '0, q);
		chk(q, 32'h0000_0755);
		apb(1'b1, 12'h000, 32'h0, q);
		per(q);
		chk(q, 32'h10);
		u_ctl.par_load(9'h155, 2'h3, 1'b0);
		low_chk();
		for (int t = 1; t < 3; t++)
		begin
			u_ctl.ser_load({3'(t), 2'h2, 9'h0A5});
			repeat (4) @(posedge clk_sys_i);
			chk(32'(cfg_o), {18'h0, 3'(t), 2'h2, 9'h0A5});
			chk({31'h0, test_o}, 32'(t == 1));
		end
		apb(1'b0, 12'h008, '0, q);
		chk(q, 32'h0000_14A5);
		u_ctl.par_load(9'h0F0, 2'h1, 1'b0);
		repeat (4) @(posedge clk_sys_i);
		chk(32'(cfg_o), 32'h0000_12F0);
		end_sim;
	end
endmodule : pll_synth_config_interface_tb_top
bind pll_synth_config_interface pll_cfg_sva u_sva (.*);
